// File: design/qbio_ports.sv
`timescale 1ns/100ps
module qbio_ports
    import qbio_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  qbio_wr_t        core_wr,
    input  wire logic [1:0] rd_port,
    input  wire logic       rd_pin_sel,
    output logic [7:0]      rd_data,
    input  qbio_xbus_t      xbus,
    input  wire logic       wr_strobe_n,
    input  wire logic       rd_strobe_n,
    input  wire logic [7:0] p1_alt_out,
    input  wire logic [7:0] p3_alt_out,
    input  wire logic [7:0] p0_in,
    input  wire logic [7:0] p1_in,
    input  wire logic [7:0] p2_in,
    input  wire logic [7:0] p3_in,
    output qbio_pin_t       p0_pin,
    output qbio_pin_t       p1_pin,
    output qbio_pin_t       p2_pin,
    output qbio_pin_t       p3_pin,
    output logic [7:0]      p0_rd_in
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0][7:0] port_latch_register;
        logic [7:0]      rd_data;
        qbio_pin_t [3:0] pin;
        logic [7:0]      p0_rd_in;
        qbio_bus_t       bus;
    } qbio_state_t;

    qbio_state_t st;
    qbio_state_t next_st;

    function automatic logic [7:0] qbio_bit_merge(input logic [7:0] cur,
                                                 input logic [2:0] sel,
                                                 input logic       val);
        logic [7:0] r;
        r = cur;
        r[sel] = val;
        return r;
    endfunction

    // ****************************************
    // Pin drivers
    // ****************************************
    logic [7:0] p3_alt_full;
    qbio_pin_t  p0_w;
    qbio_pin_t  p1_w;
    qbio_pin_t  p2_w;
    qbio_pin_t  p3_w;
    logic       p2_bus;

    always_comb begin
        p3_alt_full = p3_alt_out;
        p3_alt_full[WR_STROBE_BIT] = wr_strobe_n;
        p3_alt_full[RD_STROBE_BIT] = rd_strobe_n;
    end

    // Narrow cycles keep the latch on port 2 so software can page memory
    assign p2_bus = xbus.active && xbus.wide;

    qbio_pin_ctl u_p0 (
        .latch      (st.port_latch_register[PORT0]),
        .alt_out    (LATCH_RESET),
        .bus_sel    (xbus.active),
        .bus_val    (xbus.low_addr_data_lines),
        .bus_drive  (xbus.active && (xbus.addr_phase || xbus.drive_data)),
        .open_drain (1'b1),
        .pin        (p0_w)
    );
    qbio_pin_ctl u_p1 (
        .latch      (st.port_latch_register[PORT1]),
        .alt_out    (p1_alt_out),
        .bus_sel    (1'b0),
        .bus_val    (BYTE_ZERO),
        .bus_drive  (1'b0),
        .open_drain (1'b0),
        .pin        (p1_w)
    );
    qbio_pin_ctl u_p2 (
        .latch      (st.port_latch_register[PORT2]),
        .alt_out    (LATCH_RESET),
        .bus_sel    (p2_bus),
        .bus_val    (xbus.high_addr_lines),
        .bus_drive  (p2_bus),
        .open_drain (1'b0),
        .pin        (p2_w)
    );
    qbio_pin_ctl u_p3 (
        .latch      (st.port_latch_register[PORT3]),
        .alt_out    (p3_alt_full),
        .bus_sel    (1'b0),
        .bus_val    (BYTE_ZERO),
        .bus_drive  (1'b0),
        .open_drain (1'b0),
        .pin        (p3_w)
    );

    // ****************************************
    // Next state
    // ****************************************
    logic [7:0] cur;
    logic [7:0] pin_lvl;

    always_comb begin
        next_st = st;
        cur = st.port_latch_register[core_wr.port];
        if (core_wr.wr) begin
            case (core_wr.op)
                QBIO_OP_BYTE: begin
                    next_st.port_latch_register[core_wr.port] = core_wr.data;
                end
                QBIO_OP_SETB: begin
                    next_st.port_latch_register[core_wr.port] =
                        qbio_bit_merge(cur, core_wr.bit_sel, 1'b1);
                end
                QBIO_OP_CLRB: begin
                    next_st.port_latch_register[core_wr.port] =
                        qbio_bit_merge(cur, core_wr.bit_sel, 1'b0);
                end
                QBIO_OP_MOVB: begin
                    next_st.port_latch_register[core_wr.port] =
                        qbio_bit_merge(cur, core_wr.bit_sel, core_wr.bit_val);
                end
                default: begin
                    next_st.port_latch_register[core_wr.port] = cur;
                end
            endcase
        end
        // Bus fill wins over a core write to port 0 in the same cycle
        if (xbus.active) begin
            next_st.port_latch_register[PORT0] = P0_BUS_FILL;
        end
        case (st.bus)
            QBIO_BUS_IDLE: begin
                if (xbus.active) begin
                    next_st.bus = QBIO_BUS_ADDR;
                end
            end
            QBIO_BUS_ADDR: begin
                next_st.bus = xbus.active ? QBIO_BUS_DATA : QBIO_BUS_IDLE;
            end
            QBIO_BUS_DATA: begin
                if (!xbus.active) begin
                    next_st.bus = QBIO_BUS_IDLE;
                end
            end
            default: begin
                next_st.bus = QBIO_BUS_IDLE;
            end
        endcase
        case (rd_port)
            PORT0:   pin_lvl = p0_in;
            PORT1:   pin_lvl = p1_in;
            PORT2:   pin_lvl = p2_in;
            default: pin_lvl = p3_in;
        endcase
        // Latch reads ignore pin loading, pin reads see the pad as it stands
        next_st.rd_data = rd_pin_sel ? pin_lvl : st.port_latch_register[rd_port];
        next_st.p0_rd_in = p0_in;
        next_st.pin[PORT0] = p0_w;
        next_st.pin[PORT1] = p1_w;
        next_st.pin[PORT2] = p2_w;
        next_st.pin[PORT3] = p3_w;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Released pins at reset, so every pad starts as an input
            for (int p = 0; p < NUM_PORTS; p++) begin
                st.port_latch_register[p] <= LATCH_RESET;
                st.pin[p].out             <= LATCH_RESET;
                st.pin[p].oe_n            <= LATCH_RESET;
            end
            st.rd_data  <= BYTE_ZERO;
            st.p0_rd_in <= BYTE_ZERO;
            st.bus      <= QBIO_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data  = st.rd_data;
    assign p0_pin   = st.pin[PORT0];
    assign p1_pin   = st.pin[PORT1];
    assign p2_pin   = st.pin[PORT2];
    assign p3_pin   = st.pin[PORT3];
    assign p0_rd_in = st.p0_rd_in;
endmodule

// File: design/qbio_pkg.sv
package qbio_pkg;

    // ****************************************
    // Sizes and indices
    // ****************************************
    localparam int NUM_PORTS      = 4;
    localparam int PORT_W         = 8;
    localparam logic [1:0] PORT0  = 2'h0;
    localparam logic [1:0] PORT1  = 2'h1;
    localparam logic [1:0] PORT2  = 2'h2;
    localparam logic [1:0] PORT3  = 2'h3;
    localparam int WR_STROBE_BIT  = 6;
    localparam int RD_STROBE_BIT  = 7;

    // ****************************************
    // Reset and bus fill values
    // ****************************************
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] P0_BUS_FILL = 8'hFF;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // ****************************************
    // Core access operations
    // ****************************************
    typedef enum logic [3:0] {
        QBIO_OP_BYTE  = 4'b0001,
        QBIO_OP_SETB  = 4'b0010,
        QBIO_OP_CLRB  = 4'b0100,
        QBIO_OP_MOVB  = 4'b1000
    } qbio_op_t;

    typedef enum logic [2:0] {
        QBIO_BUS_IDLE = 3'b001,
        QBIO_BUS_ADDR = 3'b010,
        QBIO_BUS_DATA = 3'b100
    } qbio_bus_t;

    typedef struct packed {
        logic       wr;
        qbio_op_t   op;
        logic [1:0] port;
        logic [2:0] bit_sel;
        logic       bit_val;
        logic [7:0] data;
    } qbio_wr_t;

    typedef struct packed {
        logic       active;
        logic       addr_phase;
        logic       wide;
        logic       drive_data;
        logic [7:0] low_addr_data_lines;
        logic [7:0] high_addr_lines;
    } qbio_xbus_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } qbio_pin_t;

endpackage

// File: design/qbio_pin_ctl.sv
`timescale 1ns/100ps
module qbio_pin_ctl
    import qbio_pkg::*;
(
    input  wire logic [7:0] latch,
    input  wire logic [7:0] alt_out,
    input  wire logic       bus_sel,
    input  wire logic [7:0] bus_val,
    input  wire logic       bus_drive,
    input  wire logic       open_drain,
    output qbio_pin_t       pin
);
    // ****************************************
    // Per bit driver
    // ****************************************
    logic [7:0] level;
    always_comb begin
        level = (bus_sel ? bus_val : latch) & alt_out;
        for (int i = 0; i < PORT_W; i++) begin
            pin.out[i] = level[i];
            if (bus_sel && bus_drive) begin
                pin.oe_n[i] = 1'b0;
            end else if (bus_sel) begin
                pin.oe_n[i] = 1'b1;
            end else if (open_drain) begin
                pin.oe_n[i] = level[i];
            end else begin
                pin.oe_n[i] = level[i];
            end
        end
    end
endmodule

// File: sim/qbio_pin_model.sv
`timescale 1ns/100ps
// ****
// Pin and pad model
// ****
module qbio_pin_model
    import qbio_pkg::*;
#(
    parameter bit PULLUP = 1'b1
)(
    input  wire logic       sys_clk,
    input  qbio_pin_t       pin,
    input  wire logic [7:0] ext_low,
    output logic [7:0]      level
);
    // Floating pads without a pull-up wander, so a lost drive never reads as a lucky match
    logic [7:0] drift = 8'h55;
    always @(posedge sys_clk) drift <= ~drift;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_low[i]) level[i] = 1'b0;
            else if (!pin.oe_n[i]) level[i] = pin.out[i];
            else level[i] = PULLUP ? 1'b1 : drift[i];
        end
    end
endmodule

// File: sim/qbio_ports_monitor.sv
`timescale 1ns/100ps
module qbio_ports_monitor
    import qbio_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input qbio_wr_t        core_wr,
    input qbio_xbus_t      xbus,
    input wire logic       wr_strobe_n,
    input wire logic       rd_strobe_n,
    input wire logic [7:0] p1_alt_out,
    input qbio_pin_t       p0_pin,
    input qbio_pin_t       p1_pin,
    input qbio_pin_t       p2_pin,
    input qbio_pin_t       p3_pin
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RESET_PINS: assert property ($fell(rst) |-> (p1_pin.oe_n & p3_pin.oe_n) == 8'hFF)
        else $error("pins not released after reset");
    AST_P13_LEVEL: assert property (p1_pin.out == p1_pin.oe_n && p3_pin.out == p3_pin.oe_n)
        else $error("port 1 or 3 drive disagrees with level");
    AST_BYTE_WRITE: assert property (
        (core_wr.wr && core_wr.op == QBIO_OP_BYTE && core_wr.port == PORT1) ##1 !core_wr.wr
        |=> p1_pin.out == ($past(core_wr.data, 2) & $past(p1_alt_out)))
        else $error("port 1 pin misses written byte");
    AST_P0_ADDR: assert property (xbus.active && (xbus.addr_phase || xbus.drive_data) |=>
        p0_pin.oe_n == 8'h00 && p0_pin.out == $past(xbus.low_addr_data_lines))
        else $error("port 0 not driving bus value");
    AST_P0_FLOAT: assert property (xbus.active && !xbus.addr_phase && !xbus.drive_data
        |=> p0_pin.oe_n == 8'hFF)
        else $error("port 0 not floating for read");
    AST_P2_HIGH: assert property (xbus.active && xbus.wide |=>
        p2_pin.oe_n == 8'h00 && p2_pin.out == $past(xbus.high_addr_lines))
        else $error("port 2 not driving high address");
    AST_P0_OPEN: assert property (!$past(xbus.active) |->
        (p0_pin.out & ~p0_pin.oe_n) == 8'h00)
        else $error("port 0 drives a one outside bus cycles");
    AST_WR_STROBE: assert property (!wr_strobe_n |=> !p3_pin.out[WR_STROBE_BIT])
        else $error("write strobe missing on port 3");
    AST_RD_STROBE: assert property (!rd_strobe_n |=> !p3_pin.out[RD_STROBE_BIT])
        else $error("read strobe missing on port 3");
endmodule
bind qbio_ports qbio_ports_monitor mon (.sys_clk(sys_clk), .rst(rst), .core_wr(core_wr),
    .xbus(xbus), .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n), .p1_alt_out(p1_alt_out),
    .p0_pin(p0_pin), .p1_pin(p1_pin), .p2_pin(p2_pin), .p3_pin(p3_pin));

// File: sim/qbio_ports_bench.sv
`timescale 1ns/100ps
module qbio_ports_bench
    import qbio_pkg::*;
;
    logic       sys_clk, rst, rd_pin_sel, wr_strobe_n, rd_strobe_n;
    qbio_wr_t   core_wr;
    qbio_xbus_t xbus;
    logic [1:0] rd_port;
    logic [7:0] rd_data, p1_alt_out, p3_alt_out, v, p0_rd_in;
    logic [7:0] lvl [4];
    logic [7:0] ext_low [4];
    qbio_pin_t  pins [4];
    int         mismatches, comparisons;
    qbio_ports uut (.sys_clk(sys_clk), .rst(rst), .core_wr(core_wr), .rd_port(rd_port),
        .rd_pin_sel(rd_pin_sel), .rd_data(rd_data), .xbus(xbus), .wr_strobe_n(wr_strobe_n),
        .rd_strobe_n(rd_strobe_n), .p1_alt_out(p1_alt_out), .p3_alt_out(p3_alt_out),
        .p0_in(lvl[0]), .p1_in(lvl[1]), .p2_in(lvl[2]), .p3_in(lvl[3]), .p0_pin(pins[0]),
        .p1_pin(pins[1]), .p2_pin(pins[2]), .p3_pin(pins[3]), .p0_rd_in(p0_rd_in));
    for (genvar g = 0; g < 4; g++) begin : pads
        qbio_pin_model #(.PULLUP(g != 0)) pad (.sys_clk(sys_clk), .pin(pins[g]),
            .ext_low(ext_low[g]), .level(lvl[g]));
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input qbio_op_t op, input logic [1:0] p, input logic [2:0] b,
                       input logic bv, input logic [7:0] d);
        @(negedge sys_clk);
        core_wr = '{1'b1, op, p, b, bv, d};
        @(negedge sys_clk);
        core_wr.wr = 1'b0;
    endtask
    task automatic rd(input logic [1:0] p, input logic pin_sel, output logic [7:0] r);
        @(negedge sys_clk);
        rd_port = p;
        rd_pin_sel = pin_sel;
        @(negedge sys_clk);
        r = rd_data;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        for (int p = 0; p < 4; p++) begin
            rd(2'(p), 1'b0, v);
            chk("reset latch", 8'hFF, v);
            chk("reset oe_n", 8'hFF, pins[p].oe_n);
        end
    endtask
    task automatic t_byte;
        logic [7:0] d [4] = '{8'h5A, 8'h00, 8'h81, 8'hC3};
        for (int p = 0; p < 4; p++) put(QBIO_OP_BYTE, 2'(p), 3'h0, 1'b0, d[p]);
        @(negedge sys_clk);
        for (int p = 0; p < 4; p++) begin
            chk("pin oe_n", d[p], pins[p].oe_n);
            rd(2'(p), 1'b0, v);
            chk("latch read", d[p], v);
            if (p != 0) rd(2'(p), 1'b1, v);
            if (p != 0) chk("pin read", d[p], v);
        end
    endtask
    task automatic t_rmw;
        put(QBIO_OP_BYTE, PORT1, 3'h0, 1'b0, 8'hFF);
        ext_low[1] = 8'h01;
        rd(PORT1, 1'b1, v);
        chk("pulled pin", 8'hFE, v);
        put(QBIO_OP_CLRB, PORT1, 3'h5, 1'b0, 8'h00);
        put(QBIO_OP_MOVB, PORT1, 3'h2, 1'b0, 8'h00);
        put(QBIO_OP_MOVB, PORT1, 3'h5, 1'b1, 8'h00);
        put(QBIO_OP_SETB, PORT1, 3'h2, 1'b1, 8'h00);
        rd(PORT1, 1'b0, v);
        chk("bit op latch", 8'hFF, v);
        put(QBIO_OP_CLRB, PORT1, 3'h3, 1'b0, 8'h00);
        rd(PORT1, 1'b0, v);
        chk("bit op latch", 8'hF7, v);
        ext_low[1] = 8'h00;
        p1_alt_out = 8'hFE;
        p3_alt_out = 8'hFE;
        repeat (2) @(negedge sys_clk);
        chk("alt drive", 8'hF6, pins[1].out);
        chk("p3 alt drive", 8'hC2, pins[3].out);
        p1_alt_out = 8'hFF;
        p3_alt_out = 8'hFF;
    endtask
    task automatic t_bus;
        put(QBIO_OP_BYTE, PORT2, 3'h0, 1'b0, 8'h3C);
        xbus = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h34, 8'h12};
        put(QBIO_OP_BYTE, PORT0, 3'h0, 1'b0, 8'h00);
        chk("p0 addr", 8'h34, pins[0].out);
        chk("p0 oe_n", 8'h00, pins[0].oe_n);
        chk("p2 addr", 8'h12, pins[2].out);
        chk("p0 pin sample", 8'h34, p0_rd_in);
        rd(PORT0, 1'b1, v);
        chk("p0 pin read", 8'h34, v);
        xbus.addr_phase = 1'b0;
        @(negedge sys_clk);
        chk("p0 float", 8'hFF, pins[0].oe_n);
        xbus = '{1'b1, 1'b0, 1'b0, 1'b1, 8'hA5, 8'h77};
        @(negedge sys_clk);
        chk("p0 data", 8'hA5, pins[0].out);
        chk("p0 data oe_n", 8'h00, pins[0].oe_n);
        chk("p2 narrow", 8'h3C, pins[2].out);
        chk("p2 narrow oe_n", 8'h3C, pins[2].oe_n);
        xbus = '0;
        repeat (2) @(negedge sys_clk);
        chk("p2 back", 8'h3C, pins[2].out);
        rd(PORT0, 1'b0, v);
        chk("p0 fill", 8'hFF, v);
        wr_strobe_n = 1'b0;
        rd_strobe_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("strobes", 8'h00, {6'h00, pins[3].out[7:6]});
        wr_strobe_n = 1'b1;
        rd_strobe_n = 1'b1;
    endtask
    task automatic t_mid_reset;
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        {rst, wr_strobe_n, rd_strobe_n, p1_alt_out, p3_alt_out} = {3'b111, 16'hFFFF};
        {core_wr, xbus, rd_port, rd_pin_sel} = '0;
        ext_low = '{default: 8'h00};
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_byte();
        t_rmw();
        t_bus();
        t_mid_reset();
        wrap_up();
    end
endmodule
